// ### inc/asc_pkg.sv
package asc_pkg;
	// System clock and rate limits
	localparam logic [31:0] CLK_HZ     = 32'h0098_9680;
	localparam logic [16:0] BAUD_MIN   = 17'h0012C;
	localparam logic [16:0] BAUD_MAX   = 17'h1C200;
	localparam logic [16:0] BAUD_DEF   = 17'h1C200;
	localparam logic [15:0] DIV_DEF    = 16'h0056;
	localparam logic [15:0] DIV_MAX    = 16'h8235;
	localparam logic [15:0] GLITCH_MIN = 16'h0050;

	// Register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_BAUD   = 8'h04;
	localparam logic [7:0] OFS_FLOW   = 8'h08;
	localparam logic [7:0] OFS_TXCFG  = 8'h0C;
	localparam logic [7:0] OFS_TXDATA = 8'h10;
	localparam logic [7:0] OFS_RXDATA = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_INFO   = 8'h1C;

	// Field positions
	localparam int CTRL_AUTO  = 0;
	localparam int CTRL_LOOP  = 1;
	localparam int CTRL_ROLE  = 2;
	localparam int CTRL_SEVEN = 4;
	localparam int CTRL_PAR   = 5;
	localparam int CTRL_ODD   = 6;
	localparam int FLOW_RX    = 0;
	localparam int FLOW_PASS  = 2;
	localparam int FLOW_TX    = 4;
	localparam int FLOW_CONN  = 8;
	localparam int TXCFG_GAP  = 8;
	localparam int RXD_VALID  = 8;

	// Reset values
	localparam logic [1:0] RX_FLOW_DEF  = 2'h1;
	localparam logic [1:0] PASS_DEF     = 2'h0;
	localparam logic [1:0] TX_FLOW_DEF  = 2'h1;
	localparam logic [7:0] TX_SIZE_DEF  = 8'h10;
	localparam logic [7:0] TX_PAUSE_DEF = 8'h00;

	// Frame lengths
	localparam logic [3:0] DATA8      = 4'h8;
	localparam logic [3:0] FRAME_BASE = 4'hA;

	typedef enum logic [1:0] {
		ROLE_DTE  = 2'b00,
		ROLE_DCE  = 2'b01,
		ROLE_AUTO = 2'b10,
		ROLE_DIAG = 2'b11
	} asc_role_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} asc_rx_st_t;
endpackage

// ### design/asc_char_tx.sv
`timescale 1ns/1ps
module asc_char_tx (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [7:0]  data,
	input  wire logic        seven,
	input  wire logic        par_en,
	input  wire logic        par_odd,
	input  wire logic [15:0] div,
	input  wire logic [7:0]  pause,
	output logic             line,
	output logic             busy
);
	logic [10:0] shift_ff;
	logic [8:0]  left_ff;
	logic [15:0] tim_ff;
	logic        pbit;
	logic [10:0] frame;
	logic [8:0]  frame_len;

	// Parity over the bits really sent
	assign pbit = (seven ? ^data[6:0] : ^data) ^ par_odd;
	assign frame = seven ? {2'b11, par_en ? pbit : 1'b1, data[6:0], 1'b0}
	                     : {1'b1, par_en ? pbit : 1'b1, data, 1'b0};
	// Gap bits ride on as idle ones after the stop bit
	assign frame_len = {5'h00, asc_pkg::FRAME_BASE}
	                 - {8'h00, seven} + {8'h00, par_en} + {1'b0, pause};
	assign busy = left_ff != 9'h000;
	assign line = shift_ff[0];

	// Bit timer and shifter share one countdown
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_ff <= 11'h7FF;
			left_ff  <= 9'h000;
			tim_ff   <= 16'h0000;
		end else if (start && !busy) begin
			shift_ff <= frame;
			left_ff  <= frame_len;
			tim_ff   <= div - 16'h0001;
		end else if (busy && tim_ff == 16'h0000) begin
			shift_ff <= {1'b1, shift_ff[10:1]};
			left_ff  <= left_ff - 9'h001;
			tim_ff   <= div - 16'h0001;
		end else if (busy) begin
			tim_ff   <= tim_ff - 16'h0001;
		end
	end

	a_start_low: assert property (@(posedge clk) disable iff (rst)
		start && !busy |=> !line && busy)
		else $error("start bit not driven low");
endmodule // asc_char_tx

// ### design/asc_serial_port.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// What this block does
// - Rate settable 300 to 115200, default 115200
// - Configured rate seeds automatic rate measurement
// - Auto detect enable, default on; off keeps config
// - Parity detected after rate, no pause needed
// - Format sets bits, parity; default eight_bits_no_parity
// - Role fixed DTE, DCE, auto, or diagnostic
// - Diagnostic role drops data, reports detect value
// - Auto role with both lines active picks DTE
// - Throttle lines, RTS default, stop remote sending
// - Indicator lines show passthrough; else lines asserted
// - Throttle wins over passthrough on shared lines
// - Transmitter watches flow inputs, CTS default
// - Chunks up to size; flow checked per chunk
// - Idle gap in bit times between characters
// - Gap leaves receive side untouched
// - Loopback isolates pins, returns transmit data
// - Loopback still honours transmit flow control
// - Faster traffic restarts rate detection
// - Port serves channel of same index
module asc_serial_port #(
	parameter logic [7:0] CHAN_INDEX = 8'h01
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        pin2_i,
	output logic             pin2_o,
	output logic             pin2_oe,
	input  wire logic        pin3_i,
	output logic             pin3_o,
	output logic             pin3_oe,
	input  wire logic        pin2_neg,
	input  wire logic        pin3_neg,
	input  wire logic        cts,
	input  wire logic        dsr,
	output logic             rts,
	output logic             dtr
);
	// Settings
	logic                auto_ff, loop_ff, seven_ff, par_ff, odd_ff;
	asc_pkg::asc_role_t  role_ff;
	logic [16:0]         baud_ff;
	logic [1:0]          rxsel_ff, passsel_ff, txsel_ff;
	logic                conn_ff;
	logic [7:0]          txsize_ff, txgap_ff;
	// Two-stage synchronisers for all pins
	logic [5:0]          sy1_ff, sy2_ff;
	logic                p2_s, p3_s, n2_s, n3_s, cts_s, dsr_s;
	// Receive side
	asc_pkg::asc_rx_st_t rx_st_ff, nxt_rx_st;
	logic [15:0]         rx_tim_ff, nxt_rx_tim;
	logic [3:0]          rx_idx_ff, nxt_rx_idx;
	logic [7:0]          rx_sh_ff, nxt_rx_sh;
	logic                rx_pb_ff, nxt_rx_pb;
	logic [7:0]          rx_data_ff;
	logic                rx_full_ff, perr_ff, locked_ff;
	logic                det_par_ff, det_odd_ff;
	logic [15:0]         meas_div_ff, low_cnt_ff;
	logic                rx_prev_ff, baud_wr_ff;
	logic                rx_done, rx_ferr, nxt_det_set;
	// Transmit side
	logic [7:0]          tx_data_ff, chunk_ff;
	logic                tx_full_ff, tx_busy, tx_line, tx_start, tx_ok;
	logic [31:0]         rdata_ff;

	// Decoded settings and effective format
	logic        dce, diag, both_neg, rx_line, rx_read, tx_write;
	logic        f_seven, f_par, f_odd, rx_bit, faster;
	logic [15:0] cfg_div, eff_div, half_div;
	logic [31:0] div_full;
	logic [3:0]  nd;
	logic [7:0]  rx_char, detect_val;
	logic [16:0] baud_in;

	assign {p2_s, p3_s, n2_s, n3_s, cts_s, dsr_s} = sy2_ff;
	assign diag     = role_ff == asc_pkg::ROLE_DIAG;
	assign both_neg = n2_s && n3_s;
	// A negative idle only on pin 3 means we face a terminal
	assign dce = role_ff == asc_pkg::ROLE_DCE ||
	             (role_ff == asc_pkg::ROLE_AUTO && n3_s && !both_neg);
	// Clamp on the whole word so a large rate cannot wrap into range
	assign baud_in = wdata < {15'h0000, asc_pkg::BAUD_MIN} ? asc_pkg::BAUD_MIN :
	                 wdata > {15'h0000, asc_pkg::BAUD_MAX} ? asc_pkg::BAUD_MAX :
	                 wdata[16:0];
	assign div_full = asc_pkg::CLK_HZ / {15'h0000, baud_ff};
	assign cfg_div  = div_full[15:0];
	// Gap setting never enters the receive timing
	assign eff_div  = auto_ff ? meas_div_ff : cfg_div;
	assign half_div = {1'b0, eff_div[15:1]};
	assign f_seven  = auto_ff ? 1'b0 : seven_ff;
	assign f_par    = auto_ff ? det_par_ff : par_ff;
	assign f_odd    = auto_ff ? det_odd_ff : odd_ff;
	assign nd       = asc_pkg::DATA8 - {3'h0, f_seven};
	// Loopback feeds our own line back in, pins ignored
	assign rx_line  = loop_ff ? tx_line : (dce ? p3_s : p2_s);
	assign rx_bit   = rx_line;
	assign rx_char  = f_seven ? {1'b0, rx_sh_ff[7:1]} : rx_sh_ff;
	assign rx_read  = rd && addr == asc_pkg::OFS_RXDATA;
	assign tx_write = wr && addr == asc_pkg::OFS_TXDATA;
	assign detect_val = {n2_s, n3_s, p2_s, p3_s, role_ff, both_neg, dce};
	// Shorter low pulse than three quarters of a bit: faster sender
	assign faster = rx_line && !rx_prev_ff && auto_ff &&
	                low_cnt_ff >= asc_pkg::GLITCH_MIN &&
	                low_cnt_ff < eff_div - {2'b00, eff_div[15:2]};

	// Settings registers written by software
	always_ff @(posedge clk) begin
		if (rst) begin
			auto_ff    <= 1'b1;
			loop_ff    <= 1'b0;
			role_ff    <= asc_pkg::ROLE_AUTO;
			seven_ff   <= 1'b0;
			par_ff     <= 1'b0;
			odd_ff     <= 1'b0;
			baud_ff    <= asc_pkg::BAUD_DEF;
			rxsel_ff   <= asc_pkg::RX_FLOW_DEF;
			passsel_ff <= asc_pkg::PASS_DEF;
			txsel_ff   <= asc_pkg::TX_FLOW_DEF;
			conn_ff    <= 1'b0;
			txsize_ff  <= asc_pkg::TX_SIZE_DEF;
			txgap_ff   <= asc_pkg::TX_PAUSE_DEF;
		end else if (wr) begin
			unique case (addr)
				asc_pkg::OFS_CTRL: begin
					auto_ff  <= wdata[asc_pkg::CTRL_AUTO];
					loop_ff  <= wdata[asc_pkg::CTRL_LOOP];
					role_ff  <= asc_pkg::asc_role_t'(wdata[asc_pkg::CTRL_ROLE +: 2]);
					seven_ff <= wdata[asc_pkg::CTRL_SEVEN];
					par_ff   <= wdata[asc_pkg::CTRL_PAR];
					odd_ff   <= wdata[asc_pkg::CTRL_ODD];
				end
				asc_pkg::OFS_BAUD: baud_ff <= baud_in;
				asc_pkg::OFS_FLOW: begin
					rxsel_ff   <= wdata[asc_pkg::FLOW_RX +: 2];
					passsel_ff <= wdata[asc_pkg::FLOW_PASS +: 2];
					txsel_ff   <= wdata[asc_pkg::FLOW_TX +: 2];
					conn_ff    <= wdata[asc_pkg::FLOW_CONN];
				end
				asc_pkg::OFS_TXCFG: begin
					txsize_ff <= wdata[7:0];
					txgap_ff  <= wdata[asc_pkg::TXCFG_GAP +: 8];
				end
				default: ;
			endcase
		end
	end

	// Pin synchronisers; first stage read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			sy1_ff <= 6'h3F;
			sy2_ff <= 6'h3F;
		end else begin
			sy1_ff <= {pin2_i, pin3_i, pin2_neg, pin3_neg, cts, dsr};
			sy2_ff <= sy1_ff;
		end
	end

	// Receive framer, sampling mid bit
	always_comb begin
		nxt_rx_st   = rx_st_ff;
		nxt_rx_tim  = rx_tim_ff;
		nxt_rx_idx  = rx_idx_ff;
		nxt_rx_sh   = rx_sh_ff;
		nxt_rx_pb   = rx_pb_ff;
		rx_done     = 1'b0;
		rx_ferr     = 1'b0;
		nxt_det_set = 1'b0;
		if (rx_st_ff != asc_pkg::RX_IDLE && rx_tim_ff != 16'h0000) begin
			nxt_rx_tim = rx_tim_ff - 16'h0001;
		end else begin
			unique case (rx_st_ff)
				asc_pkg::RX_IDLE: if (!rx_bit) begin
					nxt_rx_st  = asc_pkg::RX_START;
					nxt_rx_tim = half_div;
				end
				asc_pkg::RX_START: begin
					nxt_rx_st  = rx_bit ? asc_pkg::RX_IDLE : asc_pkg::RX_DATA;
					nxt_rx_tim = eff_div - 16'h0001;
					nxt_rx_idx = 4'h0;
				end
				asc_pkg::RX_DATA: begin
					nxt_rx_sh  = {rx_bit, rx_sh_ff[7:1]};
					nxt_rx_idx = rx_idx_ff + 4'h1;
					nxt_rx_tim = eff_div - 16'h0001;
					if (nxt_rx_idx == nd)
						nxt_rx_st = (auto_ff || par_ff) ? asc_pkg::RX_PAR
						                                : asc_pkg::RX_STOP;
				end
				asc_pkg::RX_PAR: begin
					// A high ninth bit is already the stop bit
					if (auto_ff && rx_bit) begin
						rx_done   = 1'b1;
						nxt_rx_st = asc_pkg::RX_IDLE;
					end else begin
						nxt_rx_pb   = rx_bit;
						nxt_det_set = auto_ff;
						nxt_rx_tim  = eff_div - 16'h0001;
						nxt_rx_st   = asc_pkg::RX_STOP;
					end
				end
				asc_pkg::RX_STOP: begin
					rx_done   = rx_bit;
					rx_ferr   = !rx_bit;
					nxt_rx_st = asc_pkg::RX_IDLE;
				end
				default: nxt_rx_st = asc_pkg::RX_IDLE;
			endcase
		end
		if (faster)
			nxt_rx_st = asc_pkg::RX_IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_st_ff  <= asc_pkg::RX_IDLE;
			rx_tim_ff <= 16'h0000;
			rx_idx_ff <= 4'h0;
			rx_sh_ff  <= 8'h00;
			rx_pb_ff  <= 1'b0;
		end else begin
			rx_st_ff  <= nxt_rx_st;
			rx_tim_ff <= nxt_rx_tim;
			rx_idx_ff <= nxt_rx_idx;
			rx_sh_ff  <= nxt_rx_sh;
			rx_pb_ff  <= nxt_rx_pb;
		end
	end

	// Rate tracking: shortest low pulse is one bit
	always_ff @(posedge clk) begin
		if (rst) begin
			meas_div_ff <= asc_pkg::DIV_DEF;
			low_cnt_ff  <= 16'h0000;
			rx_prev_ff  <= 1'b1;
			locked_ff   <= 1'b0;
			baud_wr_ff  <= 1'b0;
		end else begin
			rx_prev_ff <= rx_line;
			// Seed a cycle late, once the new rate's divisor stands
			baud_wr_ff <= wr && addr == asc_pkg::OFS_BAUD;
			low_cnt_ff <= rx_line ? 16'h0000 :
			              (&low_cnt_ff ? low_cnt_ff : low_cnt_ff + 16'h0001);
			if (!auto_ff || baud_wr_ff) begin
				meas_div_ff <= cfg_div;
				locked_ff   <= 1'b0;
			end else if (faster) begin
				meas_div_ff <= low_cnt_ff;
				locked_ff   <= 1'b0;
			end else if (rx_ferr && meas_div_ff < {1'b0, asc_pkg::DIV_MAX[15:1]}) begin
				// Framing loss hints at a slower sender
				meas_div_ff <= {meas_div_ff[14:0], 1'b0};
				locked_ff   <= 1'b0;
			end else if (rx_done) begin
				locked_ff <= 1'b1;
			end
		end
	end

	// Received character holding and detected format
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_data_ff <= 8'h00;
			rx_full_ff <= 1'b0;
			perr_ff    <= 1'b0;
			det_par_ff <= 1'b0;
			det_odd_ff <= 1'b0;
		end else begin
			if (rx_done && auto_ff && rx_st_ff == asc_pkg::RX_PAR)
				det_par_ff <= 1'b0;
			if (nxt_det_set) begin
				det_par_ff <= 1'b1;
				det_odd_ff <= ^rx_sh_ff;
			end
			// New character wins over a read in the same cycle
			if (rx_done && !diag) begin
				rx_data_ff <= rx_char;
				rx_full_ff <= 1'b1;
				perr_ff    <= f_par && rx_st_ff == asc_pkg::RX_STOP &&
				              (rx_pb_ff != (^rx_char ^ f_odd));
			end else if (rx_read) begin
				rx_full_ff <= 1'b0;
			end
		end
	end

	// Modem-control outputs; throttle owns any line it is given
	logic [1:0] ctl_out;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ctl
			assign ctl_out[gi] = rxsel_ff[gi] ? !rx_full_ff :
			                     (passsel_ff[gi] ? conn_ff : 1'b1);
		end
	endgenerate
	assign rts = ctl_out[0];
	assign dtr = ctl_out[1];

	// Flow check counts only at a chunk boundary
	assign tx_ok = !(txsel_ff[0] && !cts_s) && !(txsel_ff[1] && !dsr_s);
	assign tx_start = tx_full_ff && !tx_busy &&
	                  (chunk_ff != 8'h00 || tx_ok);

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_data_ff <= 8'h00;
			tx_full_ff <= 1'b0;
			chunk_ff   <= 8'h00;
		end else begin
			if (tx_write && !tx_full_ff) begin
				tx_data_ff <= wdata[7:0];
				tx_full_ff <= 1'b1;
			end else if (tx_start) begin
				tx_full_ff <= 1'b0;
			end
			if (tx_start)
				chunk_ff <= (chunk_ff + 8'h01 >= txsize_ff) ? 8'h00
				                                            : chunk_ff + 8'h01;
			else if (!tx_full_ff && !tx_busy)
				chunk_ff <= 8'h00;
		end
	end

	asc_char_tx u_tx (
		.clk     (clk),
		.rst     (rst),
		.start   (tx_start),
		.data    (tx_data_ff),
		.seven   (f_seven),
		.par_en  (f_par),
		.par_odd (f_odd),
		.div     (eff_div),
		.pause   (txgap_ff),
		.line    (tx_line),
		.busy    (tx_busy)
	);

	// Pins: the receive pin is never driven; loopback drives none
	assign pin2_o  = tx_line;
	assign pin3_o  = tx_line;
	assign pin2_oe = !loop_ff && dce;
	assign pin3_oe = !loop_ff && !dce;

	// Read data stands one cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (rd) begin
			unique case (addr)
				asc_pkg::OFS_CTRL: rdata_ff <= {25'h0000000, odd_ff, par_ff,
				                     seven_ff, role_ff, loop_ff, auto_ff};
				asc_pkg::OFS_BAUD:   rdata_ff <= {15'h0000, baud_ff};
				asc_pkg::OFS_FLOW:   rdata_ff <= {23'h000000, conn_ff, 2'b00,
				                       txsel_ff, passsel_ff, rxsel_ff};
				asc_pkg::OFS_TXCFG:  rdata_ff <= {16'h0000, txgap_ff, txsize_ff};
				asc_pkg::OFS_RXDATA: rdata_ff <= {23'h000000, rx_full_ff, rx_data_ff};
				asc_pkg::OFS_STATUS: rdata_ff <= {eff_div, detect_val, perr_ff,
				                       det_odd_ff, det_par_ff, dce, locked_ff,
				                       tx_busy, tx_full_ff, rx_full_ff};
				asc_pkg::OFS_INFO:   rdata_ff <= {24'h000000, CHAN_INDEX};
				default:             rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end
	assign rdata = rdata_ff;

	sequence s_chunk_open;
		tx_start && chunk_ff == 8'h00;
	endsequence
	sequence s_auto_on;
		$rose(auto_ff);
	endsequence

	a_chunk_flow: assert property (@(posedge clk) disable iff (rst)
		s_chunk_open |-> tx_ok ##1 tx_busy)
		else $error("chunk opened without flow permission");
	a_chunk_bound: assert property (@(posedge clk) disable iff (rst)
		txsize_ff != 8'h00 |-> chunk_ff < txsize_ff)
		else $error("chunk longer than size");
	a_loop_quiet: assert property (@(posedge clk) disable iff (rst)
		loop_ff |-> !pin2_oe && !pin3_oe)
		else $error("pin driven in loopback");
	a_loop_flow: assert property (@(posedge clk) disable iff (rst)
		loop_ff && txsel_ff[0] && !cts_s && chunk_ff == 8'h00 |-> !tx_start)
		else $error("loopback ignored flow control");
	a_diag_drop: assert property (@(posedge clk) disable iff (rst)
		$rose(rx_full_ff) |-> $past(role_ff) != asc_pkg::ROLE_DIAG)
		else $error("data accepted in diagnostic role");
	a_role_both: assert property (@(posedge clk) disable iff (rst)
		role_ff == asc_pkg::ROLE_AUTO && both_neg |-> pin3_oe || loop_ff)
		else $error("both lines active but not terminal role");
	a_throttle_rts: assert property (@(posedge clk) disable iff (rst)
		rx_done && !diag && rxsel_ff[0] |=> !rts)
		else $error("full receiver did not throttle");
	a_pass_idle: assert property (@(posedge clk) disable iff (rst)
		passsel_ff == 2'b00 && rxsel_ff == 2'b00 |-> rts && dtr)
		else $error("unused control line not asserted");
	a_pass_prio: assert property (@(posedge clk) disable iff (rst)
		rxsel_ff[1] && passsel_ff[1] && rx_full_ff |-> !dtr)
		else $error("indication overrode throttle");
	a_rate_seed: assert property (@(posedge clk) disable iff (rst)
		s_auto_on |-> meas_div_ff == $past(cfg_div))
		else $error("measurement not seeded from setting");
endmodule // asc_serial_port

// ### tb/asc_remote_dev.sv
`timescale 1ns/1ps
// Remote serial device: eight bits, no parity, one stop
module asc_remote_dev #(
	parameter int BIT_CYC = 86
) (
	input  wire logic clk,
	input  wire logic line_in,
	output logic      line_out
);
	logic [7:0] rx_q[$];
	longint     start_q[$];
	longint     cyc;

	// Idle mark until a frame is sent
	initial line_out = 1'b1;
	initial cyc = 0;
	always @(posedge clk) cyc <= cyc + 1;

	// Frame: start low, data LSB first, stop high
	task automatic send_char(input logic [7:0] c);
		logic [9:0] frm;
		frm = {1'b1, c, 1'b0};
		@(posedge clk);
		for (int i = 0; i < 10; i++) begin
			line_out <= frm[i];
			repeat (BIT_CYC) @(posedge clk);
		end
	endtask

	// Listener samples mid bit; bad stop bit drops the char
	initial begin : listen
		logic [7:0] c;
		forever begin
			@(negedge line_in);
			start_q.push_back(cyc);
			repeat (BIT_CYC / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk);
				c[i] = line_in;
			end
			repeat (BIT_CYC) @(posedge clk);
			if (line_in === 1'b1) rx_q.push_back(c);
		end
	end
endmodule // asc_remote_dev

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        clk, rst, wr, rd, cts, dsr, pin2_neg, pin3_neg;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, v;
	logic        pin2_i, pin2_o, pin2_oe, pin3_i, pin3_o, pin3_oe;
	logic        rts, dtr, rem_line, dev_line;
	int          errors, checked, n0;

	// Wire levels resolved from the port's two pin enables
	assign dev_line = pin3_oe ? pin3_o : (pin2_oe ? pin2_o : 1'b1);
	assign pin2_i   = pin2_oe ? pin2_o : rem_line;
	assign pin3_i   = pin3_oe ? pin3_o : 1'b1;

	asc_serial_port dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pin2_i(pin2_i), .pin2_o(pin2_o),
		.pin2_oe(pin2_oe), .pin3_i(pin3_i), .pin3_o(pin3_o),
		.pin3_oe(pin3_oe), .pin2_neg(pin2_neg), .pin3_neg(pin3_neg),
		.cts(cts), .dsr(dsr), .rts(rts), .dtr(dtr));
	asc_remote_dev #(.BIT_CYC(int'(asc_pkg::DIV_DEF))) rem (.clk(clk),
		.line_in(dev_line), .line_out(rem_line));

	// 100 ns period
	initial clk = 1'b0;
	always #50 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			errors++;
		end
	endtask

	task automatic end_of_test;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Leading edge keeps two strobes out of one time step
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Bounded poll of the receive-full flag
	task automatic wait_rx;
		for (int i = 0; i < 1500; i++) begin
			rd_reg(asc_pkg::OFS_STATUS, v);
			if (v[0] === 1'b1) break;
		end
	endtask

	task automatic t_reset;
		logic [7:0]  a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h20};
		logic [31:0] e[6] = '{32'h9, 32'h1C200, 32'h11, 32'h10, 32'h1, 32'h0};
		for (int i = 0; i < 6; i++) begin
			rd_reg(a[i], v);
			chk(v, e[i]);
		end
		chk({rts, dtr, pin3_oe, pin2_oe}, 32'hE);
		wr_reg(asc_pkg::OFS_BAUD, 32'h64);
		rd_reg(asc_pkg::OFS_BAUD, v);
		chk(v, 32'h12C);
		wr_reg(asc_pkg::OFS_BAUD, 32'h30D40);
		rd_reg(asc_pkg::OFS_BAUD, v);
		chk(v, 32'h1C200);
	endtask

	task automatic t_roles;
		wr_reg(asc_pkg::OFS_CTRL, 32'h04);
		cyc(3);
		chk({pin2_oe, pin3_oe}, 32'h2);
		pin2_neg <= 1'b0;
		wr_reg(asc_pkg::OFS_CTRL, 32'h08);
		cyc(6);
		chk({pin2_oe, pin3_oe}, 32'h2);
		pin2_neg <= 1'b1;
		cyc(6);
		chk({pin2_oe, pin3_oe}, 32'h1);
		wr_reg(asc_pkg::OFS_CTRL, 32'h00);
	endtask

	task automatic t_pass;
		wr_reg(asc_pkg::OFS_FLOW, 32'h19);
		cyc(3);
		chk(dtr, 32'h0);
		wr_reg(asc_pkg::OFS_FLOW, 32'h119);
		cyc(3);
		chk(dtr, 32'h1);
		wr_reg(asc_pkg::OFS_FLOW, 32'h15);
		cyc(3);
		chk(rts, 32'h1);
		wr_reg(asc_pkg::OFS_FLOW, 32'h10);
		cyc(3);
		chk({rts, dtr}, 32'h3);
		wr_reg(asc_pkg::OFS_FLOW, 32'h11);
	endtask

	// Flow seen only at chunk start: drop mid chunk is ignored
	task automatic t_chunk;
		n0 = rem.rx_q.size();
		wr_reg(asc_pkg::OFS_TXCFG, 32'h2);
		wr_reg(asc_pkg::OFS_TXDATA, 32'h41);
		wr_reg(asc_pkg::OFS_TXDATA, 32'h42);
		cts <= 1'b0;
		// Holding must be free again or the third write is dropped
		cyc(1000);
		wr_reg(asc_pkg::OFS_TXDATA, 32'h43);
		cyc(1500);
		chk(rem.rx_q.size() - n0, 32'h2);
		chk({rem.rx_q[n0], rem.rx_q[n0+1]}, 32'h4142);
		cts <= 1'b1;
		cyc(1200);
		chk(rem.rx_q.size() - n0, 32'h3);
		chk(rem.rx_q[n0+2], 32'h43);
	endtask

	// Gap of ten bit times doubles the start-to-start spacing
	task automatic t_gap;
		longint d;
		n0 = rem.start_q.size();
		wr_reg(asc_pkg::OFS_TXCFG, 32'h0A10);
		wr_reg(asc_pkg::OFS_TXDATA, 32'h55);
		wr_reg(asc_pkg::OFS_TXDATA, 32'hAA);
		cyc(4000);
		d = rem.start_q[n0+1] - rem.start_q[n0] - 20 * 86;
		chk(d >= 0 && d <= 3, 32'h1);
	endtask

	// Auto format, gap still set; throttle owns both lines while unread
	task automatic t_rx;
		wr_reg(asc_pkg::OFS_CTRL, 32'h01);
		wr_reg(asc_pkg::OFS_FLOW, 32'h11B);
		rem.send_char(8'h5A);
		wait_rx;
		chk(v[31:16], 32'h56);
		chk(v[6:3], 32'h1);
		chk({rts, dtr}, 32'h0);
		rd_reg(asc_pkg::OFS_RXDATA, v);
		chk(v, 32'h15A);
		cyc(2);
		chk(rts, 32'h1);
		wr_reg(asc_pkg::OFS_CTRL, 32'h0C);
		rem.send_char(8'h33);
		cyc(200);
		rd_reg(asc_pkg::OFS_STATUS, v);
		chk(v[0], 32'h0);
		chk(v[15:8], 32'hFE);
	endtask

	task automatic t_loop;
		n0 = rem.start_q.size();
		wr_reg(asc_pkg::OFS_CTRL, 32'h02);
		cyc(3);
		chk({pin2_oe, pin3_oe}, 32'h0);
		cts <= 1'b0;
		wr_reg(asc_pkg::OFS_TXDATA, 32'h3C);
		cyc(1500);
		rd_reg(asc_pkg::OFS_STATUS, v);
		chk(v[0], 32'h0);
		cts <= 1'b1;
		wait_rx;
		rd_reg(asc_pkg::OFS_RXDATA, v);
		chk(v, 32'h13C);
		chk(rem.start_q.size() - n0, 32'h0);
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		end_of_test;
	end

	initial begin
		errors = 0;
		checked = 0;
		rst = 1'b1;
		{wr, rd, dsr} = 3'h1;
		cts = 1'b1;
		{pin2_neg, pin3_neg} = 2'h3;
		addr = 8'h00;
		wdata = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_roles;
		t_pass;
		t_chunk;
		t_gap;
		t_rx;
		t_loop;
		end_of_test;
	end
endmodule // testbench
